// ==== verilog/uev_map.vh ====
// Summary of operation
// - phy write: id and register in low bits
// - owner bit one means software reaches phy
// - release returns ownership; later phy writes ignored
// - eeprom read returns word at given address
// - eeprom write: address, low then high byte
// - eeprom writes need permit; forbid withdraws it
// - promiscuous forwards any address, crc check still applies, resets to zero
// - all-multicast forwards multicast, else hash decides
// - keep crc error frames when set, default drop
// - accept broadcast frames, resets to one
// - accept hashed multicast frames, resets to one
// - unicast by hash when set, default off
// - start bit runs mac, halted after reset
// - burst size code selects 2k to 16k bytes
// - back to back gap, seven bits, reset 15h
// - gap part one 0ch, part sum 12h
// - station address bytes, first byte least significant
// - eight bitmap bytes form hash, first least
// - rx control read and write share layout
// - station address has read and write codes
// - random backoff load bit, resets to zero
`ifndef UEV_MAP_VH
`define UEV_MAP_VH
// command codes
`define UEV_CMD_OWN_REQ 8'h06
`define UEV_CMD_PHY_WR 8'h08
`define UEV_CMD_OWN_STAT 8'h09
`define UEV_CMD_OWN_REL 8'h0a
`define UEV_CMD_EE_RD 8'h0b
`define UEV_CMD_EE_WR 8'h0c
`define UEV_CMD_EE_PERMIT 8'h0d
`define UEV_CMD_EE_FORBID 8'h0e
`define UEV_CMD_RXC_RD 8'h0f
`define UEV_CMD_RXC_WR 8'h10
`define UEV_CMD_GAP_RD 8'h11
`define UEV_CMD_GAP_WR 8'h12
`define UEV_CMD_STA_RD 8'h13
`define UEV_CMD_STA_WR 8'h14
`define UEV_CMD_HASH_RD 8'h15
`define UEV_CMD_HASH_WR 8'h16
`define UEV_CMD_TEST_WR 8'h17
// data stage lengths in bytes
`define UEV_LEN_PHY 4'h2
`define UEV_LEN_STAT 4'h1
`define UEV_LEN_EE 4'h2
`define UEV_LEN_RXC 4'h2
`define UEV_LEN_GAP 4'h3
`define UEV_LEN_STA 4'h6
`define UEV_LEN_HASH 4'h8
// receive control byte fields, then the test byte backoff bit
`define UEV_RXC_ALL 0
`define UEV_RXC_EVMC 1
`define UEV_RXC_KEEP 2
`define UEV_RXC_BC 3
`define UEV_RXC_HMC 4
`define UEV_RXC_UCH 5
`define UEV_RXC_SO 7
`define UEV_BACKOFF_BIT 0
// reset values
`define UEV_RST_BURST 2'h3
`define UEV_RST_GAP 7'h15
`define UEV_RST_GAP1 7'h0c
`define UEV_RST_GAP2 7'h12
`define UEV_RST_STA 48'h0000_0000_0000
`define UEV_RST_HASH 64'h0000_0000_0000_0000
// hash crc
`define UEV_CRC_POLY 32'hedb88320
`define UEV_CRC_INIT 32'hffffffff
`endif

// ==== verilog/uev_byte_bank.v ====
`timescale 1ns/1ps
// byte-writable register, byte 0 in the low bits
module uev_byte_bank #(
   parameter NBYTES = 6,
   parameter [8*NBYTES-1:0] RESET_VALUE = {8*NBYTES{1'b0}}
) (
   input wire mclk,
   input wire reset,
   input wire wr_en,
   input wire [3:0] wr_idx,
   input wire [7:0] wr_byte,
   output wire [8*NBYTES-1:0] value
);
   reg [8*NBYTES-1:0] value_reg; // stored bytes
   genvar g;
   assign value = value_reg;
   // one lane per byte, so the write decode stays flat
   generate
      for (g = 0; g < NBYTES; g = g + 1)
      begin : lane
         localparam [3:0] IDX = g; // lane index at the width of wr_idx
         always @(posedge mclk or posedge reset)
         begin
            if (reset)
               value_reg[8*g+7:8*g] <= RESET_VALUE[8*g+7:8*g];
            else if (wr_en && (wr_idx == IDX))
               value_reg[8*g+7:8*g] <= wr_byte;
         end
      end
   endgenerate
endmodule

// ==== verilog/uev_da_hash.v ====
`timescale 1ns/1ps
`include "uev_map.vh"
// crc-32 over the destination address, bit 0 of byte 0 first
module uev_da_hash (
   input wire [47:0] da,
   output wire [5:0] index
);
   reg [31:0] crc; // running remainder
   integer i;
   // unrolled by the tool; purely combinational, no state
   always @*
   begin
      crc = `UEV_CRC_INIT;
      for (i = 0; i < 48; i = i + 1)
      begin
         if (crc[0] ^ da[i])
            crc = (crc >> 1) ^ `UEV_CRC_POLY;
         else
            crc = crc >> 1;
      end
   end
   assign index = crc[31:26];
endmodule

// ==== verilog/uev_cmd_regs.v ====
`timescale 1ns/1ps
`include "uev_map.vh"
// vendor command register bank of the usb ethernet controller
module uev_cmd_regs (
   input wire mclk,
   input wire reset,
   // setup stage of a vendor request
   input wire cmd_valid,
   output wire cmd_ready,
   input wire [7:0] cmd_code,
   input wire [7:0] cmd_aa,
   input wire [7:0] cmd_bb,
   input wire [7:0] cmd_cc,
   input wire [7:0] cmd_dd,
   output wire cmd_reject,
   // data stage from host to device
   input wire out_valid,
   output wire out_ready,
   input wire [7:0] out_byte,
   // data stage from device to host
   output wire in_valid,
   input wire in_ready,
   output wire [7:0] in_byte,
   output wire in_last,
   // serial management engine
   output wire phy_wr_req,
   output wire [4:0] phy_id,
   output wire [4:0] phy_reg,
   output wire [15:0] phy_wdata,
   output wire mgmt_sw_owner,
   // serial eeprom engine
   output wire ee_rd_req,
   output wire ee_wr_req,
   output wire [7:0] ee_addr,
   output wire [15:0] ee_wdata,
   input wire ee_rd_done,
   input wire [15:0] ee_rd_data,
   // receive filter
   input wire frm_valid,
   input wire [47:0] frm_da,
   input wire frm_crc_err,
   output wire frm_done,
   output wire frm_forward,
   // mac settings
   output wire mac_run,
   output wire [1:0] usb_burst_size,
   output wire [6:0] back_to_back_gap,
   output wire [6:0] gap_part_one,
   output wire [6:0] gap_part_sum,
   output wire [47:0] station_address,
   output wire random_backoff_load
);
   // one-hot states
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_WDATA = 4'h2;
   localparam [3:0] ST_RDATA = 4'h4;
   localparam [3:0] ST_EEWAIT = 4'h8;

   reg [3:0] state_reg; // command sequencer
   reg [3:0] state_next;
   reg [7:0] code_reg; // command being served
   reg [3:0] cnt_reg; // data stage byte index
   reg [3:0] len_reg; // data stage length
   reg [7:0] in_byte_reg; // byte offered to host
   reg reject_reg; // unknown code pulse
   reg owner_reg; // software owns management
   reg permit_reg; // eeprom write permission
   reg [4:0] phy_id_reg;
   reg [4:0] phy_reg_reg;
   reg [15:0] phy_wdata_reg;
   reg phy_wr_reg; // phy write pulse
   reg ee_rd_reg; // eeprom read pulse
   reg ee_wr_reg; // eeprom write pulse
   reg [7:0] ee_addr_reg;
   reg [15:0] ee_wdata_reg;
   reg [15:0] ee_data_reg; // word returned by eeprom
   // receive control fields
   reg accept_all_frames_reg;
   reg accept_every_multicast_reg;
   reg keep_crc_error_frames_reg;
   reg accept_broadcast_reg;
   reg accept_hashed_multicast_reg;
   reg accept_unicast_by_hash_reg;
   reg start_reg;
   reg [1:0] usb_burst_size_reg;
   reg [6:0] gap_reg;
   reg [6:0] gap1_reg;
   reg [6:0] gap2_reg;
   reg random_backoff_load_reg;
   reg frm_done_reg;
   reg frm_forward_reg;
   reg [7:0] sel_byte; // read mux result
   reg [3:0] start_len; // length for a new read

   wire st_idle = state_reg[0];
   wire st_wdata = state_reg[1];
   wire st_rdata = state_reg[2];
   wire take_cmd = st_idle & cmd_valid; // setup accepted
   wire take_out = st_wdata & out_valid; // host byte accepted
   wire take_in = st_rdata & in_ready; // device byte accepted
   wire last_idx = (cnt_reg == len_reg - 4'h1);
   wire [7:0] sel_code = st_idle ? cmd_code : code_reg;
   wire [3:0] sel_idx = st_idle ? 4'h0 : cnt_reg + 4'h1;
   wire sta_wr = take_out & (code_reg == `UEV_CMD_STA_WR);
   wire hash_wr = take_out & (code_reg == `UEV_CMD_HASH_WR);
   wire [63:0] hash_map;
   wire [5:0] hash_idx;
   wire [7:0] rxc_byte;

   assign rxc_byte = {start_reg, 1'b0, accept_unicast_by_hash_reg, accept_hashed_multicast_reg,
                      accept_broadcast_reg, keep_crc_error_frames_reg, accept_every_multicast_reg,
                      accept_all_frames_reg};

   // station address, written byte by byte in transfer order
   uev_byte_bank #(
      .NBYTES(6),
      .RESET_VALUE(`UEV_RST_STA)
   ) u_station (
      .mclk(mclk),
      .reset(reset),
      .wr_en(sta_wr),
      .wr_idx(cnt_reg),
      .wr_byte(out_byte),
      .value(station_address)
   );

   // multicast hash bitmap
   uev_byte_bank #(
      .NBYTES(8),
      .RESET_VALUE(`UEV_RST_HASH)
   ) u_hash (
      .mclk(mclk),
      .reset(reset),
      .wr_en(hash_wr),
      .wr_idx(cnt_reg),
      .wr_byte(out_byte),
      .value(hash_map)
   );

   // hash index of the incoming destination address
   uev_da_hash u_da_hash (
      .da(frm_da),
      .index(hash_idx)
   );

   // read byte mux, also used to prime the first byte
   always @*
   begin
      sel_byte = 8'h00;
      start_len = 4'h0;
      case (sel_code)
         `UEV_CMD_OWN_STAT:
         begin
            sel_byte = {7'h00, owner_reg};
            start_len = `UEV_LEN_STAT;
         end
         `UEV_CMD_EE_RD:
         begin
            sel_byte = sel_idx[0] ? ee_data_reg[15:8] : ee_data_reg[7:0];
            start_len = `UEV_LEN_EE;
         end
         `UEV_CMD_RXC_RD:
         begin
            sel_byte = sel_idx[0] ? {6'h00, usb_burst_size_reg} : rxc_byte;
            start_len = `UEV_LEN_RXC;
         end
         `UEV_CMD_GAP_RD:
         begin
            // reserved top bit of each gap byte reads zero
            if (sel_idx == 4'h0)
               sel_byte = {1'b0, gap_reg};
            else if (sel_idx == 4'h1)
               sel_byte = {1'b0, gap1_reg};
            else
               sel_byte = {1'b0, gap2_reg};
            start_len = `UEV_LEN_GAP;
         end
         `UEV_CMD_STA_RD:
         begin
            sel_byte = station_address[8*sel_idx[2:0] +: 8];
            start_len = `UEV_LEN_STA;
         end
         `UEV_CMD_HASH_RD:
         begin
            sel_byte = hash_map[8*sel_idx[2:0] +: 8];
            start_len = `UEV_LEN_HASH;
         end
         default:
         begin
            sel_byte = 8'h00;
            start_len = 4'h0;
         end
      endcase
   end

   // next state of the sequencer
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (take_cmd)
            begin
               if (cmd_code == `UEV_CMD_PHY_WR || cmd_code == `UEV_CMD_STA_WR ||
                   cmd_code == `UEV_CMD_HASH_WR)
                  state_next = ST_WDATA;
               else if (cmd_code == `UEV_CMD_EE_RD)
                  state_next = ST_EEWAIT;
               else if (start_len != 4'h0)
                  state_next = ST_RDATA;
            end
         end
         ST_WDATA:
         begin
            if (take_out && last_idx)
               state_next = ST_IDLE;
         end
         ST_RDATA:
         begin
            if (take_in && last_idx)
               state_next = ST_IDLE;
         end
         ST_EEWAIT:
         begin
            if (ee_rd_done)
               state_next = ST_RDATA;
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   // sequencer, data stage bookkeeping and command side effects
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= ST_IDLE;
         code_reg <= 8'h00;
         cnt_reg <= 4'h0;
         len_reg <= 4'h0;
         in_byte_reg <= 8'h00;
         reject_reg <= 1'b0;
         owner_reg <= 1'b0;
         permit_reg <= 1'b0;
         phy_id_reg <= 5'h00;
         phy_reg_reg <= 5'h00;
         phy_wdata_reg <= 16'h0000;
         phy_wr_reg <= 1'b0;
         ee_rd_reg <= 1'b0;
         ee_wr_reg <= 1'b0;
         ee_addr_reg <= 8'h00;
         ee_wdata_reg <= 16'h0000;
         ee_data_reg <= 16'h0000;
         accept_all_frames_reg <= 1'b0;
         accept_every_multicast_reg <= 1'b0;
         keep_crc_error_frames_reg <= 1'b0;
         accept_broadcast_reg <= 1'b1;
         accept_hashed_multicast_reg <= 1'b1;
         accept_unicast_by_hash_reg <= 1'b0;
         start_reg <= 1'b0;
         usb_burst_size_reg <= `UEV_RST_BURST;
         gap_reg <= `UEV_RST_GAP;
         gap1_reg <= `UEV_RST_GAP1;
         gap2_reg <= `UEV_RST_GAP2;
         random_backoff_load_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         // pulses default low
         reject_reg <= 1'b0;
         phy_wr_reg <= 1'b0;
         ee_rd_reg <= 1'b0;
         ee_wr_reg <= 1'b0;
         if (take_cmd)
         begin
            code_reg <= cmd_code;
            cnt_reg <= 4'h0;
            len_reg <= start_len;
            in_byte_reg <= sel_byte;
            case (cmd_code)
               `UEV_CMD_OWN_REQ:
                  owner_reg <= 1'b1;
               `UEV_CMD_OWN_REL:
                  owner_reg <= 1'b0;
               `UEV_CMD_PHY_WR:
               begin
                  // reserved upper bits of both bytes dropped
                  phy_id_reg <= cmd_aa[4:0];
                  phy_reg_reg <= cmd_cc[4:0];
                  len_reg <= `UEV_LEN_PHY;
               end
               `UEV_CMD_EE_RD:
               begin
                  ee_addr_reg <= cmd_aa;
                  ee_rd_reg <= 1'b1;
                  len_reg <= `UEV_LEN_EE;
               end
               `UEV_CMD_EE_WR:
               begin
                  // without permission the request is dropped silently
                  if (permit_reg)
                  begin
                     ee_addr_reg <= cmd_aa;
                     ee_wdata_reg <= {cmd_dd, cmd_cc};
                     ee_wr_reg <= 1'b1;
                  end
               end
               `UEV_CMD_EE_PERMIT:
                  permit_reg <= 1'b1;
               `UEV_CMD_EE_FORBID:
                  permit_reg <= 1'b0;
               `UEV_CMD_RXC_WR:
               begin
                  accept_all_frames_reg <= cmd_aa[`UEV_RXC_ALL];
                  accept_every_multicast_reg <= cmd_aa[`UEV_RXC_EVMC];
                  keep_crc_error_frames_reg <= cmd_aa[`UEV_RXC_KEEP];
                  accept_broadcast_reg <= cmd_aa[`UEV_RXC_BC];
                  accept_hashed_multicast_reg <= cmd_aa[`UEV_RXC_HMC];
                  accept_unicast_by_hash_reg <= cmd_aa[`UEV_RXC_UCH];
                  start_reg <= cmd_aa[`UEV_RXC_SO];
                  usb_burst_size_reg <= cmd_bb[1:0];
               end
               `UEV_CMD_GAP_WR:
               begin
                  gap_reg <= cmd_aa[6:0];
                  gap1_reg <= cmd_bb[6:0];
                  gap2_reg <= cmd_cc[6:0];
               end
               `UEV_CMD_TEST_WR:
                  random_backoff_load_reg <= cmd_aa[`UEV_BACKOFF_BIT];
               // write stages have no read mux entry, so their length is set here
               `UEV_CMD_STA_WR:
                  len_reg <= `UEV_LEN_STA;
               `UEV_CMD_HASH_WR:
                  len_reg <= `UEV_LEN_HASH;
               `UEV_CMD_OWN_STAT, `UEV_CMD_RXC_RD, `UEV_CMD_GAP_RD, `UEV_CMD_STA_RD, `UEV_CMD_HASH_RD:
                  reject_reg <= 1'b0;
               default:
                  reject_reg <= 1'b1; // unsupported code, nothing changes
            endcase
         end
         // host bytes of the data stage
         if (take_out)
         begin
            cnt_reg <= cnt_reg + 4'h1;
            if (code_reg == `UEV_CMD_PHY_WR)
            begin
               if (cnt_reg == 4'h0)
                  phy_wdata_reg[7:0] <= out_byte;
               else
                  phy_wdata_reg[15:8] <= out_byte;
               // ignored unless software still owns the interface
               if (last_idx && owner_reg)
                  phy_wr_reg <= 1'b1;
            end
         end
         // eeprom word arrives, first byte primed for the host
         if (state_reg == ST_EEWAIT && ee_rd_done)
         begin
            ee_data_reg <= ee_rd_data;
            in_byte_reg <= ee_rd_data[7:0];
         end
         // device bytes of the data stage
         if (take_in && !last_idx)
         begin
            cnt_reg <= cnt_reg + 4'h1;
            in_byte_reg <= sel_byte;
         end
      end
   end

   // receive frame classification, one decision per presented address
   wire is_bcast = (frm_da == 48'hffff_ffff_ffff);
   wire is_mcast = frm_da[0] & ~is_bcast; // group bit of first byte
   wire is_ucast = ~frm_da[0];
   wire hash_hit = hash_map[hash_idx];
   wire mc_ok = accept_every_multicast_reg | (accept_hashed_multicast_reg & hash_hit);
   wire uc_ok = (frm_da == station_address) | (accept_unicast_by_hash_reg & hash_hit);
   wire type_ok = accept_all_frames_reg | (is_bcast & accept_broadcast_reg) |
                  (is_mcast & mc_ok) | (is_ucast & uc_ok);
   wire crc_ok = ~frm_crc_err | keep_crc_error_frames_reg;

   // decision registered so it lines up with frm_done
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         frm_done_reg <= 1'b0;
         frm_forward_reg <= 1'b0;
      end
      else
      begin
         frm_done_reg <= frm_valid;
         if (frm_valid)
            frm_forward_reg <= start_reg & type_ok & crc_ok;
      end
   end

   assign cmd_ready = st_idle;
   assign cmd_reject = reject_reg;
   assign out_ready = st_wdata;
   assign in_valid = st_rdata;
   assign in_byte = in_byte_reg;
   assign in_last = st_rdata & last_idx;
   assign phy_wr_req = phy_wr_reg;
   assign phy_id = phy_id_reg;
   assign phy_reg = phy_reg_reg;
   assign phy_wdata = phy_wdata_reg;
   assign mgmt_sw_owner = owner_reg;
   assign ee_rd_req = ee_rd_reg;
   assign ee_wr_req = ee_wr_reg;
   assign ee_addr = ee_addr_reg;
   assign ee_wdata = ee_wdata_reg;
   assign frm_done = frm_done_reg;
   assign frm_forward = frm_forward_reg;
   assign mac_run = start_reg;
   assign usb_burst_size = usb_burst_size_reg;
   assign back_to_back_gap = gap_reg;
   assign gap_part_one = gap1_reg;
   assign gap_part_sum = gap2_reg;
   assign random_backoff_load = random_backoff_load_reg;
endmodule

// ==== tb/uev_cmd_regs_checker.sv ====
`timescale 1ns/1ps
`include "uev_map.vh"
// port-level watcher of the vendor command bank
module uev_cmd_checker (
   input logic mclk,
   input logic reset,
   input logic cmd_valid,
   input logic cmd_ready,
   input logic [7:0] cmd_code,
   input logic [7:0] cmd_aa,
   input logic [7:0] cmd_bb,
   input logic [7:0] cmd_cc,
   input logic in_valid,
   input logic in_last,
   input logic phy_wr_req,
   input logic mgmt_sw_owner,
   input logic ee_rd_req,
   input logic [7:0] ee_addr,
   input logic frm_valid,
   input logic frm_done,
   input logic frm_forward,
   input logic mac_run,
   input logic [1:0] usb_burst_size,
   input logic [6:0] back_to_back_gap,
   input logic [6:0] gap_part_one,
   input logic [6:0] gap_part_sum,
   input logic random_backoff_load
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // setup request taken at this edge
   wire take = cmd_valid && cmd_ready;
   AST_OWN_SET: assert property (take && cmd_code == `UEV_CMD_OWN_REQ |=> mgmt_sw_owner)
      else $error("owner not set");
   AST_OWN_REL: assert property (take && cmd_code == `UEV_CMD_OWN_REL |=> !mgmt_sw_owner)
      else $error("owner kept");
   AST_PHY_OWNER: assert property (phy_wr_req |-> mgmt_sw_owner)
      else $error("phy write unowned");
   AST_RXC: assert property (take && cmd_code == `UEV_CMD_RXC_WR |=> mac_run == $past(cmd_aa[7]) && usb_burst_size == $past(cmd_bb[1:0]))
      else $error("rx control lost");
   AST_GAP: assert property (take && cmd_code == `UEV_CMD_GAP_WR |=> back_to_back_gap == $past(cmd_aa[6:0]) && gap_part_one == $past(cmd_bb[6:0]) && gap_part_sum == $past(cmd_cc[6:0]))
      else $error("gap lost");
   AST_EE_RD: assert property (take && cmd_code == `UEV_CMD_EE_RD |=> ee_rd_req && ee_addr == $past(cmd_aa))
      else $error("eeprom read lost");
   AST_TEST: assert property (take && cmd_code == `UEV_CMD_TEST_WR |=> random_backoff_load == $past(cmd_aa[0]))
      else $error("backoff bit lost");
   AST_FRM_DONE: assert property (frm_valid |=> frm_done)
      else $error("no decision");
   AST_FRM_CAUSE: assert property (frm_done |-> $past(frm_valid))
      else $error("stray decision");
   AST_FWD_RUN: assert property (frm_done && frm_forward |-> $past(mac_run))
      else $error("forward while halted");
   AST_IN_LAST: assert property (in_last |-> in_valid)
      else $error("stray last flag");
endmodule
bind uev_cmd_regs uev_cmd_checker u_chk (.*);

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "uev_map.vh"
module testbench;
   reg mclk = 1'b0; // 40 mhz device clock
   reg reset = 1'b1; // async, active high
   reg cmd_valid = 1'b0, out_valid = 1'b0, in_ready = 1'b1, ee_rd_done = 1'b0, frm_valid = 1'b0, frm_crc_err = 1'b0;
   reg [7:0] cmd_code = 8'h00, cmd_aa = 8'h00, cmd_bb = 8'h00, cmd_cc = 8'h00, cmd_dd = 8'h00, out_byte = 8'h00;
   reg [15:0] ee_rd_data = 16'h0000;
   reg [47:0] frm_da = 48'h0;
   wire cmd_ready, cmd_reject, out_ready, in_valid, in_last, phy_wr_req, mgmt_sw_owner, ee_rd_req, ee_wr_req;
   wire frm_done, frm_forward, mac_run, random_backoff_load;
   wire [7:0] in_byte, ee_addr;
   wire [4:0] phy_id, phy_reg;
   wire [15:0] phy_wdata, ee_wdata;
   wire [1:0] usb_burst_size;
   wire [6:0] back_to_back_gap, gap_part_one, gap_part_sum;
   wire [47:0] station_address;
   integer errors = 0, samples_checked = 0;
   integer n_phy = 0, n_eew = 0, n_rej = 0; // pulse tallies
   reg [63:0] v; // read-back scratch
   uev_cmd_regs u_dut (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
      .cmd_aa(cmd_aa), .cmd_bb(cmd_bb), .cmd_cc(cmd_cc), .cmd_dd(cmd_dd), .cmd_reject(cmd_reject),
      .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte), .in_valid(in_valid), .in_ready(in_ready),
      .in_byte(in_byte), .in_last(in_last), .phy_wr_req(phy_wr_req), .phy_id(phy_id), .phy_reg(phy_reg),
      .phy_wdata(phy_wdata), .mgmt_sw_owner(mgmt_sw_owner), .ee_rd_req(ee_rd_req), .ee_wr_req(ee_wr_req),
      .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rd_done(ee_rd_done), .ee_rd_data(ee_rd_data),
      .frm_valid(frm_valid), .frm_da(frm_da), .frm_crc_err(frm_crc_err), .frm_done(frm_done),
      .frm_forward(frm_forward), .mac_run(mac_run), .usb_burst_size(usb_burst_size),
      .back_to_back_gap(back_to_back_gap), .gap_part_one(gap_part_one), .gap_part_sum(gap_part_sum),
      .station_address(station_address), .random_backoff_load(random_backoff_load));
   // free-running clock
   always #12.5 mclk = ~mclk;
   // one-cycle pulses tallied so none is missed
   always @(posedge mclk)
   begin
      n_phy <= n_phy + (phy_wr_req === 1'b1);
      n_eew <= n_eew + (ee_wr_req === 1'b1);
      n_rej <= n_rej + (cmd_reject === 1'b1);
   end
   task check(input string what, input [63:0] seen, input [63:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   // hold valid until ready was high before an edge
   task send(input [7:0] c, input [7:0] a, input [7:0] b, input [7:0] cc, input [7:0] d);
   begin
      @(posedge mclk) #1;
      cmd_code = c;
      cmd_aa = a;
      cmd_bb = b;
      cmd_cc = cc;
      cmd_dd = d;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1)
         @(posedge mclk) #1;
      @(posedge mclk) #1;
      cmd_valid = 1'b0;
   end
   endtask
   // host-to-device data stage, low byte first
   task wr_bytes(input integer n, input [63:0] d);
   integer i;
   begin
      for (i = 0; i < n; i = i + 1)
      begin
         out_byte = d[8*i +: 8];
         out_valid = 1'b1;
         while (out_ready !== 1'b1)
            @(posedge mclk) #1;
         @(posedge mclk) #1;
      end
      out_valid = 1'b0;
   end
   endtask
   // device-to-host data stage, last flag on final byte
   task rd_bytes(input integer n, output [63:0] d);
   integer i;
   begin
      d = 64'h0;
      for (i = 0; i < n; i = i + 1)
      begin
         while (in_valid !== 1'b1)
            @(posedge mclk) #1;
         d[8*i +: 8] = in_byte;
         check("in_last", in_last, i == n - 1);
         @(posedge mclk) #1;
      end
   end
   endtask
   // lets late pulses land before tallies are read
   task settle;
   begin
      repeat (4) @(posedge mclk);
      #1;
   end
   endtask
   task t_reset;
   begin
      check("run", {mac_run, mgmt_sw_owner, random_backoff_load, usb_burst_size}, 5'h03);
      check("gaps", {back_to_back_gap, gap_part_one, gap_part_sum}, {7'h15, 7'h0c, 7'h12});
      send(`UEV_CMD_RXC_RD, 0, 0, 0, 0);
      rd_bytes(2, v);
      check("rxc", v, 64'h0318);
      send(`UEV_CMD_GAP_RD, 0, 0, 0, 0);
      rd_bytes(3, v);
      check("gap rd", v, 64'h120c15);
   end
   endtask
   task t_settings;
   integer b;
   begin
      send(`UEV_CMD_RXC_WR, 8'hff, 8'h01, 0, 0);
      send(`UEV_CMD_RXC_RD, 0, 0, 0, 0);
      rd_bytes(2, v);
      check("rxc rd", v, 64'h01bf);
      for (b = 0; b < 4; b = b + 1)
      begin
         send(`UEV_CMD_RXC_WR, 8'h18, b[7:0], 0, 0);
         check("burst", usb_burst_size, b[1:0]);
      end
      send(`UEV_CMD_GAP_WR, 8'hff, 8'h85, 8'h7f, 0);
      send(`UEV_CMD_GAP_RD, 0, 0, 0, 0);
      rd_bytes(3, v);
      check("gap rd", v, 64'h7f057f);
      send(`UEV_CMD_STA_WR, 0, 0, 0, 0);
      wr_bytes(6, 64'h665544332211);
      check("station", station_address, 48'h665544332211);
      send(`UEV_CMD_STA_RD, 0, 0, 0, 0);
      rd_bytes(6, v);
      check("sta rd", v, 64'h665544332211);
      send(`UEV_CMD_HASH_WR, 0, 0, 0, 0);
      wr_bytes(8, 64'h8877665544332211);
      send(`UEV_CMD_HASH_RD, 0, 0, 0, 0);
      rd_bytes(8, v);
      check("hash rd", v, 64'h8877665544332211);
      send(`UEV_CMD_TEST_WR, 8'h01, 0, 0, 0);
      check("backoff", random_backoff_load, 1'b1);
      send(8'h55, 0, 0, 0, 0);
      settle;
      check("reject", n_rej, 1);
   end
   endtask
   // phy write: id and register from low five bits, data lo then hi
   task phy_write(input integer exp);
   begin
      send(`UEV_CMD_PHY_WR, 8'he3, 0, 8'hfa, 0);
      wr_bytes(2, 64'hbeef);
      settle;
      check("phy pulses", n_phy, exp);
   end
   endtask
   task t_owner;
   begin
      send(`UEV_CMD_OWN_STAT, 0, 0, 0, 0);
      rd_bytes(1, v);
      check("owner rd", v, 64'h0);
      phy_write(0);
      send(`UEV_CMD_OWN_REQ, 0, 0, 0, 0);
      send(`UEV_CMD_OWN_STAT, 0, 0, 0, 0);
      rd_bytes(1, v);
      check("owner rd", v, 64'h1);
      phy_write(1);
      check("phy fields", {phy_id, phy_reg, phy_wdata}, {5'h03, 5'h1a, 16'hbeef});
      send(`UEV_CMD_OWN_REL, 0, 0, 0, 0);
      check("owner", mgmt_sw_owner, 1'b0);
      phy_write(1);
   end
   endtask
   task t_eeprom;
   integer i;
   begin
      for (i = 0; i < 3; i = i + 1)
      begin
         if (i == 1)
            send(`UEV_CMD_EE_PERMIT, 0, 0, 0, 0);
         if (i == 2)
            send(`UEV_CMD_EE_FORBID, 0, 0, 0, 0);
         send(`UEV_CMD_EE_WR, 8'h12, 0, 8'h34, 8'h56);
         settle;
         check("ee writes", n_eew, i > 0);
      end
      check("ee wr", {ee_addr, ee_wdata}, 24'h125634);
      send(`UEV_CMD_EE_RD, 8'h9a, 0, 0, 0);
      check("ee rd", {ee_rd_req, ee_addr}, 9'h19a);
      ee_rd_data = 16'hc3d2;
      ee_rd_done = 1'b1;
      @(posedge mclk) #1;
      ee_rd_done = 1'b0;
      rd_bytes(2, v);
      check("ee data", v, 64'hc3d2);
   end
   endtask
   // one frame under given rx control byte
   task frm(input [7:0] rxc, input [47:0] da, input err, input exp);
   begin
      send(`UEV_CMD_RXC_WR, rxc, 8'h03, 0, 0);
      frm_da = da;
      frm_crc_err = err;
      frm_valid = 1'b1;
      @(posedge mclk) #1;
      frm_valid = 1'b0;
      check("forward", {frm_done, frm_forward}, {1'b1, exp});
   end
   endtask
   task t_filter;
   begin
      send(`UEV_CMD_HASH_WR, 0, 0, 0, 0);
      wr_bytes(8, {64{1'b1}});
      frm(8'h18, 48'h5e0001, 0, 0);
      frm(8'h98, 48'h5e0001, 0, 1);
      frm(8'h88, 48'h5e0001, 0, 0);
      frm(8'h8a, 48'h5e0001, 0, 1);
      frm(8'h88, {48{1'b1}}, 0, 1);
      frm(8'h90, {48{1'b1}}, 0, 0);
      frm(8'h90, 48'ha2, 0, 0);
      frm(8'hb0, 48'ha2, 0, 1);
      frm(8'h81, 48'ha2, 0, 1);
      frm(8'h82, 48'h5e0001, 1, 0);
      frm(8'h86, 48'h5e0001, 1, 1);
      send(`UEV_CMD_HASH_WR, 0, 0, 0, 0);
      wr_bytes(8, 64'h0);
      frm(8'h98, 48'h5e0001, 0, 0);
      frm(8'hb0, 48'ha2, 0, 0);
   end
   endtask
   task results;
   begin
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   // watchdog well past the few hundred cycles expected
   initial
   begin
      #500000;
      errors = errors + 1;
      results;
   end
   initial
   begin
      repeat (20) @(posedge mclk);
      #1 reset = 1'b0;
      t_reset;
      t_settings;
      t_owner;
      t_eeprom;
      t_filter;
      results;
   end
endmodule
